// File: ietc_chan.sv
/*
 * One event transfer channel: source and destination pointers, counter and
 * mode bits. Assumes a register write and a service never need both to act.
 */
`timescale 1ns/10ps
module ietc_chan
    import ietc_pkg::*;
#(
    parameter int PTR_W = PTR_WIDTH
) (
    input wire logic ref_clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic wrEn, // Register write strobe
    input wire logic [1:0] wrWord, // Word within channel
    input wire logic [31:0] wdata, // Write data
    input wire logic serve, // One transfer done this cycle
    output logic [PTR_W-1:0] srcPtr, // Source pointer
    output logic [PTR_W-1:0] dstPtr, // Destination pointer
    output ietc_chctl_t ctl // Counter and mode
);
    typedef struct packed {
        logic [PTR_W-1:0] src;
        logic [PTR_W-1:0] dst;
        ietc_chctl_t ctl;
    } ietc_chst_t;

    ietc_chst_t r, n;
    logic [PTR_W-1:0] step;

    assign step = r.ctl.wordSize ? PTR_W'(2) : PTR_W'(1);

    always_comb begin
        n = r;
        // Software reload wins so a reprogrammed block starts clean
        if (wrEn) begin
            case (wrWord)
                CH_SRC: n.src = wdata[PTR_W-1:0];
                CH_DST: n.dst = wdata[PTR_W-1:0];
                CH_CTL: n.ctl = ietc_chctl_t'(wdata[CT_W-1:0]);
                default: n = r;
            endcase
        end else if (serve) begin
            if (r.ctl.incSrc) begin
                n.src = r.src + step; // [RL5]
            end
            if (r.ctl.incDst) begin
                n.dst = r.dst + step; // [RL5]
            end
            if (!r.ctl.continuous) begin
                n.ctl.count = r.ctl.count - 8'h01; // [RL6]
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign srcPtr = r.src;
    assign dstPtr = r.dst;
    assign ctl = r.ctl;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_CHAN_DEC: assert property ( // [RL6]
        (serve && !wrEn && !r.ctl.continuous) |=> (r.ctl.count == $past(r.ctl.count) - 8'h01))
        else $error("Counter not decremented on service");
    AST_CHAN_CONT: assert property ( // [RL6]
        (serve && !wrEn && r.ctl.continuous) |=> $stable(r.ctl.count))
        else $error("Counter moved in continuous mode");
    AST_CHAN_INC: assert property ( // [RL5]
        (serve && !wrEn && r.ctl.incSrc && r.ctl.wordSize) |=> (r.src == $past(r.src) + 2))
        else $error("Word source pointer not advanced by two");
endmodule

// File: ietc_cpu_model.sv
/*
 * Behavioural CPU core: acknowledges presented requests after a set delay
 * and logs stolen transfer cycles. Assumes the single clock ref_clk.
 */
`timescale 1ns/10ps
module ietc_cpu_model
    import ietc_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [3:0] ackDelay, // Cycles before acknowledge
    input wire logic cpuReq, // Presented request
    input wire logic [7:0] cpuTrap, // Trap number
    input wire logic [15:0] cpuVector, // Vector offset
    input wire logic xferValid, // Stolen cycle
    input wire logic [PTR_WIDTH-1:0] xferSrc, // Transfer source
    input wire logic [PTR_WIDTH-1:0] xferDst, // Transfer destination
    output logic cpuAck, // Acknowledge pulse
    output logic [7:0] lastTrap, // Trap taken at last ack
    output logic [15:0] lastVec, // Vector taken at last ack
    output logic [PTR_WIDTH-1:0] lastSrc, // Last transfer source
    output logic [PTR_WIDTH-1:0] lastDst, // Last transfer destination
    output int nAck, // Acknowledges given
    output int nXfer // Transfers seen
);
    logic [3:0] waitCnt;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpuAck <= 1'b0;
            waitCnt <= 4'h0;
            nAck <= 0;
            nXfer <= 0;
        end else if (cpuAck) begin
            // One pulse only; request drops the cycle after
            cpuAck <= 1'b0;
            lastTrap <= cpuTrap;
            lastVec <= cpuVector;
            nAck <= nAck + 1;
        end else if (cpuReq === 1'b1 && waitCnt == ackDelay) begin
            cpuAck <= 1'b1;
            waitCnt <= 4'h0;
        end else if (cpuReq === 1'b1) begin
            waitCnt <= waitCnt + 4'h1;
        end
        if (rst_n && xferValid === 1'b1) begin
            nXfer <= nXfer + 1;
            lastSrc <= xferSrc;
            lastDst <= xferDst;
        end
    end
endmodule

// File: ietc_ctrl.sv
/*
 * Interrupt controller with eight event transfer channels, APB registers,
 * fast external inputs and a vectored request port to the CPU core.
 * Assumes request pulses on ref_clk from peripherals; the CPU acknowledges
 * a presented request with one cycle of cpuAck and then moves the data of
 * each transfer strobe in the stolen cycle.
 */
// Our own choices: the placing of the registers and the APB interface to the registers.
//
// Functional notes
// RL1 - Present accepted interrupt within seven clocks
// RL2 - Each node selects vectored or engine service
// RL3 - Vectored service branches to node vector
// RL4 - Engine service steals exactly one cycle
// RL5 - Move byte or word, bump chosen pointers
// RL6 - Counter decrements unless continuous mode
// RL7 - Counter at zero raises vectored interrupt
// RL8 - Eight independent transfer channels
// RL9 - Node word: request, enable, priority
// RL10 - Sixteen priority levels per node
// RL11 - Only strictly higher priority preempts
// RL12 - One dedicated vector per node
// RL13 - Vector is trap number times four
// RL14 - External inputs: rise, fall or both
// RL15 - Software trap invokes its numbered vector
// RL16 - Software may set any request bit
// RL17 - Some nodes merge two request sources
// RL18 - Highest pending level above CPU wins
`timescale 1ns/10ps
module ietc_ctrl
    import ietc_pkg::*;
#(
    parameter int NODES = NODE_COUNT,
    parameter int CHANS = CHAN_COUNT,
    parameter int EXTS = EXT_COUNT,
    parameter int PTR_W = PTR_WIDTH,
    parameter logic [NODES-1:0] ALT_MASK = ALT_MASK_DEF
) (
    input wire logic ref_clk, // 125 MHz system clock
    input wire logic rst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [NODES-1:0] periphReq, // Primary request pulses
    input wire logic [NODES-1:0] altReq, // Second source pulses
    input wire logic [EXTS-1:0] extPin, // Fast external pins
    input wire logic cpuAck, // CPU takes presented request
    output logic cpuReq, // Request presented to CPU
    output logic [7:0] cpuTrap, // Trap number presented
    output logic [15:0] cpuVector, // Vector offset presented
    output logic [3:0] cpuLevel, // Level of presented request
    output logic xferValid, // Stolen transfer cycle
    output logic xferWord, // Word rather than byte
    output logic [PTR_W-1:0] xferSrc, // Transfer source address
    output logic [PTR_W-1:0] xferDst, // Transfer destination address
    output logic irq // Channel completion interrupt
);
    localparam int IDX_W = $clog2(NODES);
    localparam int CH_W = $clog2(CHANS);
    localparam int RESP_HI = RESP_CLK_FAST;

    typedef struct packed {
        logic found;
        logic [3:0] prio;
        logic [IDX_W-1:0] idx;
    } ietc_pick_t;

    typedef struct packed {
        ietc_node_t [NODES-1:0] node;
        logic [3:0] runLevel;
        logic [CHANS-1:0] status;
        logic [CHANS-1:0] mask;
        logic [2*EXTS-1:0] edgeMode;
        logic trapPend;
        logic [7:0] trapNo;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic req;
        logic fromTrap;
        logic [IDX_W-1:0] reqNode;
        logic [7:0] trap;
        logic [15:0] vector;
        logic [3:0] level;
        logic xValid;
        logic xWord;
        logic [PTR_W-1:0] xSrc;
        logic [PTR_W-1:0] xDst;
        logic irq;
    } ietc_state_t;

    ietc_state_t r, n;
    ietc_chctl_t [CHANS-1:0] chCtl;
    logic [CHANS-1:0][PTR_W-1:0] chSrc;
    logic [CHANS-1:0][PTR_W-1:0] chDst;
    logic [CHANS-1:0] chWr;
    logic [CHANS-1:0] chServe;
    logic [CHANS-1:0] doneEvt;
    logic [EXTS-1:0] extEvt;
    logic [NODES-1:0] extNode;
    logic [NODES-1:0] evt;
    logic [NODES-1:0] engOk;
    logic [NODES-1:0] vecCand;
    ietc_pick_t engPick;
    ietc_pick_t vecPick;
    logic [CH_W-1:0] engChan;
    logic access;
    logic wrAcc;
    logic rdAcc;
    logic nodeHit;
    logic chanHit;
    logic miscHit;
    logic ackNow;
    logic [IDX_W-1:0] nodeIdx;
    logic [CH_W-1:0] chanIdx;
    logic [7:0] vecTrap;

    function automatic logic [15:0] vecOf(input logic [7:0] trapNum);
        vecOf = {6'h00, trapNum, 2'b00}; // [RL13]
    endfunction

    // Ties go to the lowest node index
    function automatic ietc_pick_t pickBest(input logic [NODES-1:0] cand,
                                            input ietc_node_t [NODES-1:0] nd);
        ietc_pick_t p;
        p = '0;
        for (int i = 0; i < NODES; i++) begin
            if (cand[i] && (!p.found || (nd[i].prio > p.prio))) begin
                p.found = 1'b1;
                p.prio = nd[i].prio; // [RL10]
                p.idx = IDX_W'(i);
            end
        end
        return p;
    endfunction

    for (genvar c = 0; c < CHANS; c++) begin : g_chan
        ietc_chan #(
            .PTR_W(PTR_W)
        ) u_chan (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .wrEn(chWr[c]),
            .wrWord(paddr[3:2]),
            .wdata(pwdata),
            .serve(chServe[c]),
            .srcPtr(chSrc[c]),
            .dstPtr(chDst[c]),
            .ctl(chCtl[c])
        ); // [RL8]
    end

    for (genvar e = 0; e < EXTS; e++) begin : g_ext
        ietc_edge u_edge (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .pinIn(extPin[e]),
            .mode(ietc_edge_t'(r.edgeMode[2*e+:2])),
            .edgePulse(extEvt[e])
        );
    end

    // APB: answer one cycle after setup, so the access phase is one cycle
    assign access = psel & penable & r.pready;
    assign wrAcc = access & pwrite;
    assign rdAcc = access & ~pwrite;
    assign nodeHit = (paddr[11:8] == OFS_NODE[11:8]) && (int'(paddr[7:2]) < NODES) &&
                     (paddr[1:0] == 2'b00);
    assign chanHit = (paddr[11:8] == OFS_CHAN[11:8]) && (int'(paddr[7:4]) < CHANS) &&
                     (paddr[3:2] != 2'h3) && (paddr[1:0] == 2'b00);
    assign miscHit = (paddr == OFS_CPU_LEVEL) || (paddr == OFS_STATUS) ||
                     (paddr == OFS_MASK) || (paddr == OFS_TRAP) || (paddr == OFS_EDGE);
    assign nodeIdx = IDX_W'(paddr[7:2]);
    assign chanIdx = CH_W'(paddr[7:4]);
    assign extNode = NODES'(extEvt);
    assign evt = periphReq | (ALT_MASK & altReq) | extNode; // [RL17] [RL14]
    assign ackNow = cpuAck & r.req;

    always_comb begin
        for (int i = 0; i < NODES; i++) begin
            // A drained counter hands the node back to the vectored path
            engOk[i] = r.node[i].request && r.node[i].enable && r.node[i].useEngine &&
                       (chCtl[r.node[i].chan].continuous ||
                        (chCtl[r.node[i].chan].count != 8'h00)); // [RL2]
            vecCand[i] = r.node[i].request && r.node[i].enable && !engOk[i]; // [RL7]
        end
    end

    assign engPick = pickBest(engOk, r.node);
    assign vecPick = pickBest(vecCand, r.node); // [RL18]
    assign engChan = CH_W'(r.node[engPick.idx].chan);
    assign vecTrap = TRAP_BASE + 8'(vecPick.idx); // [RL12]

    always_comb begin
        for (int c = 0; c < CHANS; c++) begin
            chWr[c] = wrAcc && chanHit && (chanIdx == CH_W'(c));
            chServe[c] = engPick.found && (engChan == CH_W'(c)); // [RL4]
            doneEvt[c] = chServe[c] && !chWr[c] && !chCtl[c].continuous &&
                         (chCtl[c].count == 8'h01);
        end
    end

    always_comb begin
        n = r;
        n.pready = psel & ~penable & ~r.pready;
        n.pslverr = 1'b0;
        n.prdata = '0;
        if (psel && !penable) begin
            n.pslverr = !(nodeHit || chanHit || miscHit);
            if (nodeHit) begin
                n.prdata = 32'(r.node[nodeIdx]); // [RL9]
            end else if (chanHit) begin
                case (paddr[3:2])
                    CH_SRC: n.prdata = 32'(chSrc[chanIdx]);
                    CH_DST: n.prdata = 32'(chDst[chanIdx]);
                    default: n.prdata = 32'(chCtl[chanIdx]);
                endcase
            end else begin
                case (paddr)
                    OFS_CPU_LEVEL: n.prdata = 32'(r.runLevel);
                    OFS_STATUS: n.prdata = 32'(r.status);
                    OFS_MASK: n.prdata = 32'(r.mask);
                    OFS_TRAP: n.prdata = 32'({r.trapPend, r.trapNo});
                    OFS_EDGE: n.prdata = 32'(r.edgeMode);
                    default: n.prdata = '0;
                endcase
            end
        end

        // Node words: software write, then hardware clear, then set wins
        for (int i = 0; i < NODES; i++) begin
            if (wrAcc && nodeHit && (nodeIdx == IDX_W'(i))) begin
                n.node[i] = ietc_node_t'(pwdata[NODE_W-1:0]); // [RL9] [RL16]
                n.node[i].zero = 2'b00;
            end
            // Draining service keeps the request for the vectored path
            if (engPick.found && (engPick.idx == IDX_W'(i)) && !doneEvt[engChan]) begin
                n.node[i].request = 1'b0; // [RL7]
            end
            if (ackNow && !r.fromTrap && (r.reqNode == IDX_W'(i))) begin
                n.node[i].request = 1'b0;
            end
            if (evt[i]) begin
                n.node[i].request = 1'b1;
            end
        end

        // Read clears status; a completion in the same cycle survives
        n.status = (rdAcc && (paddr == OFS_STATUS)) ? '0 : r.status;
        n.status = n.status | doneEvt;
        if (wrAcc && (paddr == OFS_MASK)) begin
            n.mask = pwdata[CHANS-1:0];
        end
        if (wrAcc && (paddr == OFS_EDGE)) begin
            n.edgeMode = pwdata[2*EXTS-1:0];
        end
        if (wrAcc && (paddr == OFS_CPU_LEVEL)) begin
            n.runLevel = pwdata[3:0];
        end
        if (ackNow) begin
            n.runLevel = r.level; // [RL11]
            if (r.fromTrap) begin
                n.trapPend = 1'b0;
            end
        end
        if (wrAcc && (paddr == OFS_TRAP)) begin
            n.trapPend = 1'b1; // [RL15]
            n.trapNo = pwdata[7:0];
        end

        // Presentation is re-evaluated every cycle until taken
        n.req = 1'b0;
        if (!ackNow) begin
            if (r.trapPend) begin
                n.req = 1'b1;
                n.fromTrap = 1'b1;
                n.trap = r.trapNo;
                n.vector = vecOf(r.trapNo); // [RL15]
                n.level = r.runLevel;
            end else if (vecPick.found && (vecPick.prio > n.runLevel)) begin
                n.req = 1'b1; // [RL1] [RL11]
                n.fromTrap = 1'b0;
                n.reqNode = vecPick.idx;
                n.trap = vecTrap;
                n.vector = vecOf(vecTrap); // [RL3]
                n.level = vecPick.prio;
            end
        end

        // Transfer strobe holds the bus for exactly this one cycle
        n.xValid = engPick.found; // [RL4]
        n.xWord = chCtl[engChan].wordSize; // [RL5]
        n.xSrc = chSrc[engChan];
        n.xDst = chDst[engChan];
        n.irq = |(n.status & n.mask);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.runLevel <= CPU_LEVEL_RST;
            r.mask <= MASK_RST;
            r.edgeMode <= EDGE_RST;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign cpuReq = r.req;
    assign cpuTrap = r.trap;
    assign cpuVector = r.vector;
    assign cpuLevel = r.level;
    assign xferValid = r.xValid;
    assign xferWord = r.xWord;
    assign xferSrc = r.xSrc;
    assign xferDst = r.xDst;
    assign irq = r.irq;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence trapWrite;
        psel && penable && pready && pwrite && (paddr == OFS_TRAP) && !r.trapPend;
    endsequence

    sequence nodeEligible;
        !r.req && !r.trapPend && vecPick.found && (vecPick.prio > r.runLevel) &&
        !(wrAcc && (nodeHit || (paddr == OFS_CPU_LEVEL)));
    endsequence

    AST_RESPONSE: assert property ( // [RL1]
        nodeEligible |-> ##[1:RESP_HI] cpuReq)
        else $error("Eligible request not presented in time");
    AST_PREEMPT: assert property ( // [RL11]
        (cpuReq && !r.fromTrap) |-> (cpuLevel > r.runLevel))
        else $error("Presented level not above running level");
    AST_VECTOR: assert property ( // [RL13]
        (cpuReq && !r.fromTrap) |-> (cpuVector == 16'(({8'h00, TRAP_BASE} + r.reqNode) * 4)))
        else $error("Vector is not trap number times four");
    AST_TRAP: assert property ( // [RL15]
        (trapWrite and (!cpuReq || !cpuAck)) |=> ##1 (cpuReq && (cpuTrap == $past(pwdata[7:0], 2))))
        else $error("Software trap not presented with its number");
    AST_ZERO_IRQ: assert property ( // [RL7]
        (|doneEvt) |=> (|r.status))
        else $error("Drained channel did not flag completion");
    AST_STEAL: assert property ( // [RL4]
        engPick.found |=> (xferValid && $stable(cpuReq) || $past(ackNow) || $changed(r.trapPend)
                           || !$past(r.req)))
        else $error("Transfer cycle disturbed program flow");
endmodule

// File: ietc_edge.sv
/*
 * Fast external interrupt input: two-stage synchroniser and selectable
 * edge detection. Assumes an asynchronous pin and one clock domain.
 */
`timescale 1ns/10ps
module ietc_edge
    import ietc_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic pinIn, // Raw pin level
    input wire ietc_edge_t mode, // Edge selection
    output logic edgePulse // One-cycle detected edge
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic pulse;
    } ietc_edst_t;

    ietc_edst_t r, n;

    always_comb begin
        n = r;
        n.s1 = pinIn;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.pulse = (((mode == EDGE_RISE) || (mode == EDGE_BOTH)) && r.s2 && !r.s3) ||
                  (((mode == EDGE_FALL) || (mode == EDGE_BOTH)) && !r.s2 && r.s3); // [RL14]
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign edgePulse = r.pulse;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_EDGE_RISE: assert property ( // [RL14]
        (mode == EDGE_RISE && r.s2 && !r.s3) |=> edgePulse)
        else $error("Rising edge not reported");
endmodule

// File: ietc_pkg.sv
/*
 * Shared constants and carriers of the interrupt and event transfer controller:
 * register offsets, field layouts, reset values, edge modes and timing counts.
 * Assumes a 32-bit APB register bus with 12 address bits.
 */
package ietc_pkg;
    localparam int NODE_COUNT = 16;
    localparam int CHAN_COUNT = 8;
    localparam int EXT_COUNT = 2;
    localparam int PTR_WIDTH = 24;
    localparam int NODE_W = 12;
    localparam int CT_W = 12;
    localparam logic [7:0] TRAP_BASE = 8'h10;
    localparam logic [15:0] ALT_MASK_DEF = 16'hF0FC;
    // Byte offsets; node n at OFS_NODE + 4*n, channel c at OFS_CHAN + 16*c
    localparam logic [11:0] OFS_NODE = 12'h000;
    localparam logic [11:0] OFS_CHAN = 12'h100;
    localparam logic [11:0] OFS_CPU_LEVEL = 12'h200;
    localparam logic [11:0] OFS_STATUS = 12'h204;
    localparam logic [11:0] OFS_MASK = 12'h208;
    localparam logic [11:0] OFS_TRAP = 12'h20C;
    localparam logic [11:0] OFS_EDGE = 12'h210;
    // Word select inside one channel
    localparam logic [1:0] CH_SRC = 2'h0;
    localparam logic [1:0] CH_DST = 2'h1;
    localparam logic [1:0] CH_CTL = 2'h2;
    // Reset values
    localparam logic [3:0] CPU_LEVEL_RST = 4'h0;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [3:0] EDGE_RST = 4'h0;
    // CPU clocks of the minimum response, without and with jump cache
    localparam int RESP_CLK_FAST = 7;
    localparam int RESP_CLK_CACHE = 11;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } ietc_edge_t;

    // Node control word, bits 11..0
    typedef struct packed {
        logic [2:0] chan;
        logic useEngine;
        logic request;
        logic enable;
        logic [1:0] zero;
        logic [3:0] prio;
    } ietc_node_t;

    // Channel control word, bits 11..0
    typedef struct packed {
        logic continuous;
        logic incDst;
        logic incSrc;
        logic wordSize;
        logic [7:0] count;
    } ietc_chctl_t;
endpackage

// File: test_ietc_ctrl.sv
/*
 * Self-checking bench of ietc_ctrl with a CPU core model.
 * Assumes the zero-wait APB slave and register map of the design.
 */
`timescale 1ns/10ps
module test_ietc_ctrl
    import ietc_pkg::*;
();
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, q, prdata;
    logic [15:0] periphReq = 0, altReq = 0, cpuVector, lastVec;
    logic [1:0] extPin = 0;
    logic [3:0] ackDelay = 0, cpuLevel;
    logic pready, pslverr, cpuReq, cpuAck, xferValid, xferWord, irq;
    logic [7:0] cpuTrap, lastTrap;
    logic [PTR_WIDTH-1:0] xferSrc, xferDst, lastSrc, lastDst;
    int nAck, nXfer, nErrors = 0, nTests = 0, acks = 0, n;
    always #4 ref_clk = ~ref_clk;
    ietc_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periphReq(periphReq), .altReq(altReq), .extPin(extPin),
        .cpuAck(cpuAck), .cpuReq(cpuReq), .cpuTrap(cpuTrap), .cpuVector(cpuVector),
        .cpuLevel(cpuLevel), .xferValid(xferValid), .xferWord(xferWord),
        .xferSrc(xferSrc), .xferDst(xferDst), .irq(irq));
    ietc_cpu_model i_cpu (.ref_clk(ref_clk), .rst_n(rst_n), .ackDelay(ackDelay),
        .cpuReq(cpuReq), .cpuTrap(cpuTrap), .cpuVector(cpuVector), .xferValid(xferValid),
        .xferSrc(xferSrc), .xferDst(xferDst), .cpuAck(cpuAck), .lastTrap(lastTrap),
        .lastVec(lastVec), .lastSrc(lastSrc), .lastDst(lastDst), .nAck(nAck),
        .nXfer(nXfer));
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge keeps back-to-back calls from double driving psel
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    task automatic pulse(input int i);
        periphReq[i] <= 1'b1;
        @(posedge ref_clk);
        periphReq[i] <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic take(input logic [7:0] t, input string nm);
        int k;
        k = 0;
        acks++;
        while (nAck < acks && k < 60) begin
            @(posedge ref_clk);
            k++;
        end
        chk("ackwait", 32'(nAck), 32'(acks));
        chk(nm, {24'h0, lastTrap}, {24'h0, t});
        chk("vector", {16'h0, lastVec}, {22'h0, t, 2'b00});
    endtask
    initial begin
        #100000;
        nErrors++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(OFS_CPU_LEVEL, 32'h0, "level");
        rd(OFS_MASK, 32'h0, "mask");
        apb(1'b1, 12'h028, 32'h0000_004F);
        rd(12'h028, 32'h0000_004F, "node10");
        apb(1'b1, 12'h170, 32'h00AB_CDEF);
        rd(12'h170, 32'h00AB_CDEF, "ch7src");
        rd(12'h180, 32'h0, "ch8");
        chk("slverr", {31'h0, err}, 32'h1);
        // Slow core first
        ackDelay <= 4'h3;
        apb(1'b1, 12'h00C, 32'h0000_0045);
        pulse(3);
        n = 0;
        while (cpuReq !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        chk("latency", 32'(n <= RESP_CLK_FAST), 32'h1);
        chk("reqlvl", {28'h0, cpuLevel}, 32'h5);
        take(8'h13, "node3");
        rd(OFS_CPU_LEVEL, 32'h5, "level");
        ackDelay <= 4'h0;
        apb(1'b1, 12'h010, 32'h0000_0045);
        pulse(4);
        repeat (8) @(posedge ref_clk);
        chk("equal", {31'h0, cpuReq}, 32'h0);
        apb(1'b1, 12'h018, 32'h0000_0046);
        altReq[6] <= 1'b1;
        @(posedge ref_clk);
        altReq[6] <= 1'b0;
        take(8'h16, "alt6");
        apb(1'b1, OFS_CPU_LEVEL, 32'h0);
        take(8'h14, "node4");
        // Channel 1: two word transfers, both pointers bumped
        apb(1'b1, 12'h110, 32'h0000_0100);
        apb(1'b1, 12'h114, 32'h0000_0200);
        apb(1'b1, 12'h118, 32'h0000_0702);
        apb(1'b1, OFS_MASK, 32'h0000_0002);
        apb(1'b1, 12'h020, 32'h0000_0342);
        for (int i = 0; i < 2; i++) begin
            pulse(8);
            @(posedge ref_clk);
            chk("xword", {30'h0, xferValid, xferWord}, 32'h3);
            @(posedge ref_clk);
            chk("src", {8'h0, lastSrc}, 32'h0000_0100 + 32'(2 * i));
            chk("dst", {8'h0, lastDst}, 32'h0000_0200 + 32'(2 * i));
            chk("xfers", 32'(nXfer), 32'(i + 1));
            chk("noack", 32'(nAck), 32'(acks));
        end
        rd(12'h118, 32'h0000_0700, "count");
        chk("irq", {31'h0, irq}, 32'h1);
        rd(OFS_STATUS, 32'h0000_0002, "status");
        rd(OFS_STATUS, 32'h0, "status");
        chk("irq", {31'h0, irq}, 32'h0);
        chk("drainwait", {31'h0, cpuReq}, 32'h0);
        apb(1'b1, OFS_CPU_LEVEL, 32'h0);
        take(8'h18, "zero");
        apb(1'b1, 12'h118, 32'h0000_0801);
        pulse(8);
        repeat (2) @(posedge ref_clk);
        rd(12'h118, 32'h0000_0801, "cont");
        chk("src", {8'h0, lastSrc}, 32'h0000_0104);
        apb(1'b1, OFS_TRAP, 32'h0000_0025);
        take(8'h25, "trap");
        apb(1'b1, 12'h024, 32'h0000_00C7);
        take(8'h19, "soft");
        apb(1'b1, OFS_EDGE, 32'h0000_0002);
        apb(1'b1, OFS_NODE, 32'h0000_0049);
        extPin[0] <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk("rise", 32'(nAck), 32'(acks));
        extPin[0] <= 1'b0;
        take(8'h10, "fall");
        end_sim();
    end
endmodule
